// *** verilog/pcd_pkg.sv ***
package pcd_pkg;

  // special-function register offsets on the core's register port
  localparam logic [7:0] PCD_OFS_POLARITY   = 8'hae;
  localparam logic [7:0] PCD_OFS_CTRL_LO    = 8'hc2;
  localparam logic [7:0] PCD_OFS_CTRL_HI    = 8'hc3;
  localparam logic [7:0] PCD_OFS_DATA       = 8'hd8;
  localparam logic [7:0] PCD_OFS_PIN0_LO    = 8'h84;
  localparam logic [7:0] PCD_OFS_PIN0_HI    = 8'h85;
  localparam logic [7:0] PCD_OFS_PIN1_LO    = 8'h94;
  localparam logic [7:0] PCD_OFS_PIN1_HI    = 8'h95;
  localparam logic [7:0] PCD_OFS_PIN2_LO    = 8'hac;
  localparam logic [7:0] PCD_OFS_PIN2_HI    = 8'had;
  localparam logic [7:0] PCD_OFS_PIN3_LO    = 8'hb4;
  localparam logic [7:0] PCD_OFS_PIN3_HI    = 8'hb5;

  // field positions inside a control byte (upper pin / lower pin half)
  localparam int         PCD_FUNC_UP_LSB    = 6;
  localparam int         PCD_CMP_UP_LSB     = 4;
  localparam int         PCD_FUNC_DN_LSB    = 2;
  localparam int         PCD_CMP_DN_LSB     = 0;
  // polarity bits sit in bits 7..4, pin 3 at the top
  localparam int         PCD_POL_LSB        = 4;

  // reset values
  localparam logic [7:0] PCD_RST_CTRL       = 8'h00;
  localparam logic [3:0] PCD_RST_POL        = 4'h0;
  localparam logic [3:0] PCD_RST_DATA       = 4'hf;
  localparam logic [15:0] PCD_RST_BASE      = 16'h0000;

  typedef enum logic [1:0] {
    PCD_GPIO = 2'h0,
    PCD_RD   = 2'h1,
    PCD_WR   = 2'h2,
    PCD_RW   = 2'h3
  } pcd_func_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pcd_sfr_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd_n;
    logic        wr_n;
  } pcd_xbus_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pcd_pins_s;

endpackage

// *** verilog/pcd_addr_match.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcd_addr_match
  import pcd_pkg::*;
(
  // address and window
  input  wire logic [15:0] addr,
  input  wire logic [15:0] base,
  input  wire logic [1:0]  cmp_len,
  // result
  output logic             hit
);
  logic [15:0] mask;

  always_comb begin
    unique case (cmp_len)
      2'h0: mask = 16'hffff; // R5
      2'h1: mask = 16'hfffe; // R6
      2'h2: mask = 16'hfffc; // R7
      2'h3: mask = 16'hff00; // R8
    endcase
    hit = ((addr ^ base) & mask) == 16'h0000;
  end
endmodule
`default_nettype wire

// *** verilog/pcd_pin_mux.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcd_pin_mux
  import pcd_pkg::*;
(
  // configuration
  input  wire pcd_func_e func,
  input  wire logic      pol,
  // cycle state
  input  wire logic      hit,
  input  wire logic      rd_n,
  input  wire logic      wr_n,
  input  wire logic      gpio_bit,
  // pin drive
  output logic           out,
  output logic           oe
);
  logic active;

  always_comb begin
    unique case (func)
      PCD_GPIO: active = 1'b0;
      PCD_RD:   active = hit & ~rd_n;            // R2 R16
      PCD_WR:   active = hit & ~wr_n;            // R3 R15 R16
      PCD_RW:   active = hit & (~rd_n | ~wr_n);  // R4
    endcase
    if (func == PCD_GPIO) begin
      // quasi-bidirectional: only a low is driven, the pull-up gives high
      out = 1'b0; // R1
      oe  = ~gpio_bit; // R1 R14
    end else begin
      // idle level is the inverse of the active level
      out = pol ? active : ~active; // R11 R12 R18
      oe  = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verilog/pcd_port4.sv ***
// Contract
// R1 - function 00: plain quasi-bidirectional port bit
// R2 - function 01: strobe on matching read cycles
// R3 - function 10: strobe on matching write cycles
// R4 - function 11: strobe on matching read or write
// R5 - length 00: compare all sixteen address bits
// R6 - length 01: ignore address bit zero
// R7 - length 10: ignore two lowest address bits
// R8 - length 11: compare only the high byte
// R9 - upper control: pin3 bits 7..4, pin2 3..0
// R10 - lower control: pin1 bits 7..4, pin0 3..0
// R11 - pin3 polarity: one high, zero low active
// R12 - pins 2..0 polarity in bits 6..4
// R13 - per-pin base address in two bytes
// R14 - data bits 3..0 drive general-purpose pins
// R15 - matching data write gives write strobe
// R16 - strobes follow core read/write enable pulses
// R17 - pins 2, 3 feed extra interrupts
// R18 - idle strobe pin holds its inactive level
`timescale 1ns/1ns
`default_nettype none
module pcd_port4
  import pcd_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // core register port
  input  wire pcd_pkg::pcd_sfr_req_s sfr_req,
  output logic [7:0]              sfr_rdata,
  output logic                    sfr_hit,
  // core external data cycle
  input  wire pcd_pkg::pcd_xbus_s xbus,
  // pins
  input  wire logic [3:0]         pin_in,
  output var pcd_pkg::pcd_pins_s  pins,
  // extra interrupt enables and inputs towards the interrupt logic
  input  wire logic               irq_a_en,
  input  wire logic               irq_b_en,
  output logic                    extra_ext_irq_a_n,
  output logic                    extra_ext_irq_b_n
);
  import pcd_pkg::*;

  typedef struct packed {
    logic [3:0]       pol;
    logic [7:0]       ctrl_lo;
    logic [7:0]       ctrl_hi;
    logic [3:0]       data;
    logic [3:0][15:0] base;
    pcd_pins_s        pins;
    logic [7:0]       rdata;
    logic             hit;
    logic             irq_a_n;
    logic             irq_b_n;
  } pcd_state_s;

  pcd_state_s st_reg;
  pcd_state_s st_next;

  logic [3:0]      hit_w;
  pcd_func_e [3:0] func_w;
  logic [3:0][1:0] cmp_w;
  pcd_pins_s       pins_w;

  // pin 3/1 in the high half of a control byte, pin 2/0 in the low half
  assign func_w[3] = pcd_func_e'(st_reg.ctrl_hi[PCD_FUNC_UP_LSB +: 2]); // R9
  assign cmp_w[3]  = st_reg.ctrl_hi[PCD_CMP_UP_LSB +: 2]; // R9
  assign func_w[2] = pcd_func_e'(st_reg.ctrl_hi[PCD_FUNC_DN_LSB +: 2]); // R9
  assign cmp_w[2]  = st_reg.ctrl_hi[PCD_CMP_DN_LSB +: 2]; // R9
  assign func_w[1] = pcd_func_e'(st_reg.ctrl_lo[PCD_FUNC_UP_LSB +: 2]); // R10
  assign cmp_w[1]  = st_reg.ctrl_lo[PCD_CMP_UP_LSB +: 2]; // R10
  assign func_w[0] = pcd_func_e'(st_reg.ctrl_lo[PCD_FUNC_DN_LSB +: 2]); // R10
  assign cmp_w[0]  = st_reg.ctrl_lo[PCD_CMP_DN_LSB +: 2]; // R10

  for (genvar i = 0; i < 4; i++) begin : g_pin
    pcd_addr_match u_match (
      .addr    (xbus.addr),
      .base    (st_reg.base[i]),
      .cmp_len (cmp_w[i]),
      .hit     (hit_w[i])
    );
    pcd_pin_mux u_mux (
      .func     (func_w[i]),
      .pol      (st_reg.pol[i]),
      .hit      (hit_w[i]),
      .rd_n     (xbus.rd_n),
      .wr_n     (xbus.wr_n),
      .gpio_bit (st_reg.data[i]),
      .out      (pins_w.out[i]),
      .oe       (pins_w.oe[i])
    );
  end

  function automatic logic [7:0] base_byte(input logic [15:0] b,
                                           input logic hi);
    base_byte = hi ? b[15:8] : b[7:0];
  endfunction

  always_comb begin
    st_next       = st_reg;
    // pins follow the core enables with one register stage of delay
    st_next.pins  = pins_w; // R16
    st_next.hit   = 1'b0;
    st_next.rdata = 8'h00;
    // extra interrupts see the pin only in general-purpose mode
    // pin 3 feeds the second extra interrupt, pin 2 the third
    st_next.irq_a_n = ~(irq_a_en && func_w[3] == PCD_GPIO) | pin_in[3]; // R17
    st_next.irq_b_n = ~(irq_b_en && func_w[2] == PCD_GPIO) | pin_in[2]; // R17
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        PCD_OFS_POLARITY: st_next.pol = sfr_req.wdata[PCD_POL_LSB +: 4]; // R11 R12
        PCD_OFS_CTRL_LO:  st_next.ctrl_lo = sfr_req.wdata; // R10
        PCD_OFS_CTRL_HI:  st_next.ctrl_hi = sfr_req.wdata; // R9
        PCD_OFS_DATA:     st_next.data = sfr_req.wdata[3:0]; // R14
        PCD_OFS_PIN0_LO:  st_next.base[0][7:0]  = sfr_req.wdata; // R13
        PCD_OFS_PIN0_HI:  st_next.base[0][15:8] = sfr_req.wdata; // R13
        PCD_OFS_PIN1_LO:  st_next.base[1][7:0]  = sfr_req.wdata; // R13
        PCD_OFS_PIN1_HI:  st_next.base[1][15:8] = sfr_req.wdata; // R13
        PCD_OFS_PIN2_LO:  st_next.base[2][7:0]  = sfr_req.wdata; // R13
        PCD_OFS_PIN2_HI:  st_next.base[2][15:8] = sfr_req.wdata; // R13
        PCD_OFS_PIN3_LO:  st_next.base[3][7:0]  = sfr_req.wdata; // R13
        PCD_OFS_PIN3_HI:  st_next.base[3][15:8] = sfr_req.wdata; // R13
        default: ;
      endcase
    end
    if (sfr_req.rd) begin
      st_next.hit = 1'b1;
      unique case (sfr_req.addr)
        PCD_OFS_POLARITY: st_next.rdata = {st_reg.pol, 4'h0};
        PCD_OFS_CTRL_LO:  st_next.rdata = st_reg.ctrl_lo;
        PCD_OFS_CTRL_HI:  st_next.rdata = st_reg.ctrl_hi;
        // port read returns pin levels, like the standard ports
        PCD_OFS_DATA:     st_next.rdata = {4'h0, pin_in};
        PCD_OFS_PIN0_LO:  st_next.rdata = base_byte(st_reg.base[0], 1'b0);
        PCD_OFS_PIN0_HI:  st_next.rdata = base_byte(st_reg.base[0], 1'b1);
        PCD_OFS_PIN1_LO:  st_next.rdata = base_byte(st_reg.base[1], 1'b0);
        PCD_OFS_PIN1_HI:  st_next.rdata = base_byte(st_reg.base[1], 1'b1);
        PCD_OFS_PIN2_LO:  st_next.rdata = base_byte(st_reg.base[2], 1'b0);
        PCD_OFS_PIN2_HI:  st_next.rdata = base_byte(st_reg.base[2], 1'b1);
        PCD_OFS_PIN3_LO:  st_next.rdata = base_byte(st_reg.base[3], 1'b0);
        PCD_OFS_PIN3_HI:  st_next.rdata = base_byte(st_reg.base[3], 1'b1);
        default:          st_next.hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.pol     <= PCD_RST_POL;
      st_reg.ctrl_lo <= PCD_RST_CTRL;
      st_reg.ctrl_hi <= PCD_RST_CTRL;
      st_reg.data    <= PCD_RST_DATA;
      st_reg.base    <= {4{PCD_RST_BASE}};
      st_reg.pins    <= '0;
      st_reg.rdata   <= 8'h00;
      st_reg.hit     <= 1'b0;
      st_reg.irq_a_n <= 1'b1;
      st_reg.irq_b_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins              = st_reg.pins;
  assign sfr_rdata         = st_reg.rdata;
  assign sfr_hit           = st_reg.hit;
  assign extra_ext_irq_a_n = st_reg.irq_a_n;
  assign extra_ext_irq_b_n = st_reg.irq_b_n;
endmodule
`default_nettype wire

// *** bench/pcd_periph_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcd_periph_model
  import pcd_pkg::*;
(
  // pin drive from the port
  input  wire pcd_pkg::pcd_pins_s pins,
  // resolved pin levels
  output logic [3:0]              pin_in
);
  // pull-up on each pin: an undriven pin reads high
  always_comb pin_in = (pins.out & pins.oe) | ~pins.oe;
endmodule
`default_nettype wire

// *** bench/pcd_port4_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcd_port4_chk
  import pcd_pkg::*;
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // watched ports
  input wire pcd_pkg::pcd_sfr_req_s sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  sfr_hit,
  input wire pcd_pkg::pcd_xbus_s    xbus,
  input wire logic [3:0]            pin_in,
  input wire pcd_pkg::pcd_pins_s    pins,
  input wire logic                  irq_a_en,
  input wire logic                  irq_b_en,
  input wire logic                  extra_ext_irq_a_n,
  input wire logic                  extra_ext_irq_b_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic act1;
  logic act2;
  // a strobe edge lags its cause by one cycle, its release and a data-write pin edge by two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act1 <= 1'b0;
      act2 <= 1'b0;
    end else begin
      act1 <= !xbus.rd_n || !xbus.wr_n || sfr_req.wr;
      act2 <= act1;
    end
  end
  sequence s_rd(logic [7:0] a);
    sfr_req.rd && sfr_req.addr == a;
  endsequence
  a_rd_quiet: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00 && !sfr_hit)
    else $error("read data without read");
  a_data_read: assert property (s_rd(PCD_OFS_DATA) |=> sfr_hit
    && sfr_rdata == {4'h0, $past(pin_in)}) else $error("data read wrong");
  a_pol_read: assert property (s_rd(PCD_OFS_POLARITY) |=> sfr_hit
    && sfr_rdata[3:0] == 4'h0) else $error("polarity low bits set");
  a_unmapped_read: assert property (s_rd(8'h00) |=> !sfr_hit
    && sfr_rdata == 8'h00) else $error("unmapped read answered");
  a_gpio_out_low: assert property ((pins.out & ~pins.oe) == 4'h0)
    else $error("undriven pin drives high");
  a_irq_a_off: assert property (!irq_a_en |=> extra_ext_irq_a_n)
    else $error("disabled irq a asserted");
  a_irq_b_src: assert property (!extra_ext_irq_b_n |-> $past(irq_b_en)
    && !$past(pin_in[2])) else $error("irq b without low pin");
  a_irq_a_src: assert property (!extra_ext_irq_a_n |-> $past(irq_a_en)
    && !$past(pin_in[3])) else $error("irq a without low pin");
  a_strobe_cause: assert property ($changed(pins.out) |-> act1 || act2)
    else $error("pin changed without cycle");
endmodule
bind pcd_port4 pcd_port4_chk pcd_port4_chk_inst (.clk(clk), .resetn(resetn),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .xbus(xbus),
  .pin_in(pin_in), .pins(pins), .irq_a_en(irq_a_en), .irq_b_en(irq_b_en),
  .extra_ext_irq_a_n(extra_ext_irq_a_n), .extra_ext_irq_b_n(extra_ext_irq_b_n));
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pcd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic irq_a_en = 1'b0;
  logic irq_b_en = 1'b0;
  pcd_sfr_req_s req = '0;
  pcd_xbus_s xb = '{16'h0000, 1'b1, 1'b1};
  pcd_pins_s pins;
  logic [7:0] rdata;
  logic [3:0] pin_in;
  logic ia_n, ib_n;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] ofs [12] = '{PCD_OFS_POLARITY, PCD_OFS_DATA, PCD_OFS_CTRL_LO,
    PCD_OFS_CTRL_HI, PCD_OFS_PIN0_LO, PCD_OFS_PIN0_HI, PCD_OFS_PIN1_LO,
    PCD_OFS_PIN1_HI, PCD_OFS_PIN2_LO, PCD_OFS_PIN2_HI, PCD_OFS_PIN3_LO,
    PCD_OFS_PIN3_HI};
  logic [15:0] ad [5] = '{16'h1234, 16'h1235, 16'h1236, 16'h12ff, 16'h1334};
  logic [15:0] msk [4] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
  always #10 clk = ~clk;
  pcd_port4 pcd_port4_inst (.clk(clk), .resetn(resetn), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_hit(), .xbus(xb), .pin_in(pin_in), .pins(pins),
    .irq_a_en(irq_a_en), .irq_b_en(irq_b_en), .extra_ext_irq_a_n(ia_n),
    .extra_ext_irq_b_n(ib_n));
  pcd_periph_model pcd_periph_model_inst (.pins(pins), .pin_in(pin_in));
  task automatic end_of_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req = '{a, 1'b1, 1'b0, d};
    @(negedge clk) req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk) req.rd = 1'b0;
    chk(rdata, e);
  endtask
  // one external cycle, pin checked while active and once idle
  task automatic xc(input logic [15:0] a, input logic w, input int i,
                    input logic e, input logic idle);
    @(negedge clk) xb = '{a, w, !w};
    @(negedge clk) chk(pins.out[i], e);
    xb = '{a, 1'b1, 1'b1};
    @(negedge clk) chk(pins.out[i], idle);
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 12; i++) rd(ofs[i], (i == 1) ? 8'h0f : 8'h00);
    for (int i = 2; i < 12; i++) wr(ofs[i], 8'h30 + 8'(i));
    for (int i = 2; i < 12; i++) rd(ofs[i], 8'h30 + 8'(i));
    wr(PCD_OFS_POLARITY, 8'hff);
    rd(PCD_OFS_POLARITY, 8'hf0);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    wr(PCD_OFS_CTRL_LO, 8'h00);
    wr(PCD_OFS_CTRL_HI, 8'h00);
    wr(PCD_OFS_DATA, 8'ha5);
    // pins follow the data register one cycle later
    @(negedge clk);
    rd(PCD_OFS_DATA, 8'h05);
    chk(pins.oe, 4'ha);
    irq_a_en = 1'b1;
    wr(PCD_OFS_DATA, 8'h04);
    repeat (2) @(negedge clk);
    chk({ia_n, ib_n}, 2'b01);
    irq_b_en = 1'b1;
    repeat (2) @(negedge clk);
    chk({ia_n, ib_n}, 2'b01);
    wr(PCD_OFS_DATA, 8'h08);
    repeat (2) @(negedge clk);
    chk({ia_n, ib_n}, 2'b10);
    wr(PCD_OFS_DATA, 8'h0f);
    wr(PCD_OFS_PIN0_HI, 8'h12);
    wr(PCD_OFS_PIN0_LO, 8'h34);
    wr(PCD_OFS_PIN3_HI, 8'h12);
    wr(PCD_OFS_PIN3_LO, 8'h34);
    wr(PCD_OFS_POLARITY, 8'h10);
    for (int f = 0; f < 4; f++) begin
      wr(PCD_OFS_CTRL_LO, 8'(f * 4 + 2));
      for (int w = 0; w < 2; w++) begin
        xc(16'h1237, w[0], 0, f == 3 || f == w + 1, 1'b0);
        xc(16'h1238, w[0], 0, 1'b0, 1'b0);
      end
    end
    chk(pins.oe[0], 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(PCD_OFS_CTRL_HI, 8'(8'hc0 + c * 16));
      for (int j = 0; j < 5; j++)
        xc(ad[j], j[0], 3, |((ad[j] ^ 16'h1234) & msk[c]), 1'b1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
